//--- verilog/dse_pkg.sv
// package for the pll status and event register group
package dse_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets within the register port
  localparam logic [1:0] DSE_OFS_STATUS   = 2'h0;
  localparam logic [1:0] DSE_OFS_EVENTS   = 2'h1;
  localparam logic [1:0] DSE_OFS_LOSS_CNT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int DSE_STATE_LSB     = 4;
  localparam int DSE_REF_BIT       = 1;
  localparam int DSE_LOCK_BIT      = 0;
  localparam int DSE_EV_STATE_BIT  = 3;
  localparam int DSE_EV_HOLD_BIT   = 2;
  localparam int DSE_EV_LIMIT_BIT  = 1;
  localparam int DSE_EV_LOSS_BIT   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // values
  localparam logic [3:0] DSE_CNT_MAX      = 4'hf;
  localparam logic [3:0] DSE_CNT_RESET    = 4'h0;
  localparam logic [3:0] DSE_EV_RESET     = 4'h0;
  localparam logic [3:0] DSE_THRESH_DFLT  = 4'h8;
  localparam logic [2:0] DSE_STATE_HOLD   = 3'h2;
  localparam logic [2:0] DSE_STATE_RESET  = 3'h0;

  // loop state codes as reported
  typedef enum logic [2:0] {
    DSE_FREERUN   = 3'h0,
    DSE_NORMAL    = 3'h1,
    DSE_HOLDOVER  = 3'h2,
    DSE_WRITE_FRQ = 3'h3,
    DSE_ACQUIRE   = 3'h4,
    DSE_HITLESS   = 3'h5
  } dse_loop_state_type;

  // live inputs from the loop
  typedef struct packed {
    logic [2:0] state;
    logic       ref_sel;
    logic       locked;
  } dse_loop_type;

  // register port request
  typedef struct packed {
    logic       wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } dse_req_type;

  // whole module state
  typedef struct packed {
    logic [2:0] state;
    logic       ref_sel;
    logic       locked;
    logic [3:0] events;
    logic [3:0] loss_cnt;
    logic [7:0] rdata;
  } dse_regs_type;

endpackage

//--- verilog/dse_regs.sv
// status, event and lock-loss counter registers of the loop
`timescale 1ns/100ps
module dse_regs
#(
  parameter logic [3:0] LOSS_THRESH = dse_pkg::DSE_THRESH_DFLT
)
(
  // clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset_n,
  // loop side, same clock domain
  input  wire dse_pkg::dse_loop_type i_loop,
  input  wire logic                 i_clock_gated,
  input  wire logic                 i_loop_soft_reset,
  // register port
  input  wire dse_pkg::dse_req_type i_req,
  input  wire logic [1:0]           i_raddr,
  output logic [7:0]                o_rdata
);
  import dse_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // widths of the event and counter fields inside the 8-bit registers
  localparam int EV_BITS  = 4;
  localparam int CNT_BITS = 4;

  // every register, the read data included, leaves reset at its idle value
  localparam dse_regs_type REGS_RESET = '{
    state:    DSE_STATE_RESET,
    ref_sel:  1'b0,
    locked:   1'b0,
    events:   DSE_EV_RESET,
    loss_cnt: DSE_CNT_RESET,
    rdata:    8'h00
  };

  ////////////////////////////////////////////////////////////////////////////
  // state and next state
  dse_regs_type       r_q;
  dse_regs_type       r_d;

  // write decode
  logic               wr_events;
  logic               wr_count;
  logic               cnt_wr_open;
  logic               cnt_wr_take;

  // event sources
  logic               state_moved;
  logic               hold_entry;
  logic               lock_fall;
  logic               over_thresh;
  logic               cnt_at_max;

  // event update terms
  logic [EV_BITS-1:0] clr;
  logic               ev_state_next;
  logic               ev_hold_next;
  logic               ev_limit_next;
  logic               ev_loss_next;

  // read words
  logic [7:0]         status_word;
  logic [7:0]         event_word;
  logic [7:0]         count_word;

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  assign wr_events   = i_req.wr && (i_req.addr == DSE_OFS_EVENTS);
  assign wr_count    = i_req.wr && (i_req.addr == DSE_OFS_LOSS_CNT);
  // a gated or soft-reset loop must not see its counter written under it
  assign cnt_wr_open = !i_clock_gated && !i_loop_soft_reset;
  assign cnt_wr_take = wr_count && cnt_wr_open;

  ////////////////////////////////////////////////////////////////////////////
  // event sources, live inputs against the copy taken at the previous edge
  assign state_moved = (i_loop.state != r_q.state);
  assign hold_entry  = (i_loop.state == DSE_STATE_HOLD) && (r_q.state != DSE_STATE_HOLD);
  assign lock_fall   = r_q.locked && !i_loop.locked;
  // registered count: the limit flag stays set through a clear while the count is still over
  assign over_thresh = (r_q.loss_cnt > LOSS_THRESH);
  assign cnt_at_max  = (r_q.loss_cnt == DSE_CNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // only ones written to the event register clear a flag
  always_comb
  begin
    clr = '0;
    if (wr_events)
    begin
      clr = i_req.wdata[EV_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one sticky cell per event flag; set wins over a clear in the same cycle
  dse_w1c_cell #(
    .WIDTH  (1)
  ) u_ev_state (
    .i_cur  (r_q.events[DSE_EV_STATE_BIT]),
    .i_set  (state_moved),
    .i_clr  (clr[DSE_EV_STATE_BIT]),
    .o_next (ev_state_next)
  );

  dse_w1c_cell #(
    .WIDTH  (1)
  ) u_ev_hold (
    .i_cur  (r_q.events[DSE_EV_HOLD_BIT]),
    .i_set  (hold_entry),
    .i_clr  (clr[DSE_EV_HOLD_BIT]),
    .o_next (ev_hold_next)
  );

  dse_w1c_cell #(
    .WIDTH  (1)
  ) u_ev_limit (
    .i_cur  (r_q.events[DSE_EV_LIMIT_BIT]),
    .i_set  (over_thresh),
    .i_clr  (clr[DSE_EV_LIMIT_BIT]),
    .o_next (ev_limit_next)
  );

  dse_w1c_cell #(
    .WIDTH  (1)
  ) u_ev_loss (
    .i_cur  (r_q.events[DSE_EV_LOSS_BIT]),
    .i_set  (lock_fall),
    .i_clr  (clr[DSE_EV_LOSS_BIT]),
    .o_next (ev_loss_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read words, reserved bits stay zero
  always_comb
  begin
    status_word = 8'h00;
    status_word[DSE_STATE_LSB +: 3] = r_q.state;
    status_word[DSE_REF_BIT] = r_q.ref_sel;
    status_word[DSE_LOCK_BIT] = r_q.locked;
    event_word = 8'h00;
    event_word[EV_BITS-1:0] = r_q.events;
    count_word = 8'h00;
    count_word[CNT_BITS-1:0] = r_q.loss_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    r_d = r_q;
    // status copies, one edge behind the loop
    r_d.state = i_loop.state;
    r_d.ref_sel = i_loop.ref_sel;
    r_d.locked = i_loop.locked;
    // event flags
    r_d.events[DSE_EV_STATE_BIT] = ev_state_next;
    r_d.events[DSE_EV_HOLD_BIT] = ev_hold_next;
    r_d.events[DSE_EV_LIMIT_BIT] = ev_limit_next;
    r_d.events[DSE_EV_LOSS_BIT] = ev_loss_next;
    // counter: a write wins over an increment in the same cycle
    if (cnt_wr_take)
    begin
      r_d.loss_cnt = i_req.wdata[CNT_BITS-1:0];
    end
    else if (lock_fall && !cnt_at_max)
    begin
      r_d.loss_cnt = r_q.loss_cnt + 4'h1;
    end
    // read data answers the address one edge later
    case (i_raddr)
      DSE_OFS_STATUS:
      begin
        r_d.rdata = status_word;
      end
      DSE_OFS_EVENTS:
      begin
        r_d.rdata = event_word;
      end
      DSE_OFS_LOSS_CNT:
      begin
        r_d.rdata = count_word;
      end
      default:
      begin
        r_d.rdata = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      r_q <= REGS_RESET;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_rdata = r_q.rdata;

endmodule

////////////////////////////////////////////////////////////////////////////////
// next value of write-one-to-clear flags; set beats clear so no event is lost
module dse_w1c_cell
#(
  parameter int WIDTH = 1
)
(
  // present value and its update terms
  input  wire logic [WIDTH-1:0] i_cur,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic [WIDTH-1:0] i_clr,
  // next value
  output logic [WIDTH-1:0]      o_next
);

  assign o_next = (i_cur & ~i_clr) | i_set;

endmodule

//--- testbench/dse_regs_monitor.sv
// concurrent checks on the pll status and event register ports
`timescale 1ns/100ps
module dse_regs_monitor
#(parameter logic [3:0] LOSS_THRESH = dse_pkg::DSE_THRESH_DFLT)
(
  input wire logic                  i_sys_clk,
  input wire logic                  i_reset_n,
  input wire dse_pkg::dse_loop_type i_loop,
  input wire logic                  i_clock_gated,
  input wire logic                  i_loop_soft_reset,
  input wire dse_pkg::dse_req_type  i_req,
  input wire logic [1:0]            i_raddr,
  input wire logic [7:0]            o_rdata
);
  import dse_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // read data lags the read address by one edge and the loop inputs by two
  sequence s_over; $past(i_raddr) == 2'h2 && o_rdata[3:0] > LOSS_THRESH; endsequence
  sequence s_ev_rd; $past(i_raddr) == 2'h1; endsequence
  a_status_view: assert property ($past(i_raddr) == 2'h0 |-> o_rdata == {1'b0, $past(i_loop.state, 2), 2'h0,
    $past(i_loop.ref_sel, 2), $past(i_loop.locked, 2)}) else $error("status view wrong");
  a_state_moved: assert property (s_ev_rd ##0 $past(i_loop.state, 3) != $past(i_loop.state, 2) |-> o_rdata[3])
    else $error("state change event missing");
  a_hold_entry: assert property (s_ev_rd ##0 $past(i_loop.state, 2) == DSE_STATE_HOLD
    && $past(i_loop.state, 3) != DSE_STATE_HOLD |-> o_rdata[2]) else $error("holdover event missing");
  a_lock_lost: assert property (s_ev_rd ##0 $past(i_loop.locked, 3) && !$past(i_loop.locked, 2) |-> o_rdata[0])
    else $error("loss event missing");
  a_limit_flag: assert property (s_over ##1 s_ev_rd |-> o_rdata[1]) else $error("limit flag missing");
  a_cnt_load: assert property ($past(i_req.wr, 2) && $past(i_req.addr, 2) == 2'h2 && !$past(i_clock_gated, 2)
    && !$past(i_loop_soft_reset, 2) && $past(i_raddr) == 2'h2 |-> o_rdata == {4'h0, $past(i_req.wdata[3:0], 2)})
    else $error("counter load wrong");
  a_rsv_upper: assert property ($past(i_raddr) != 2'h0 |-> o_rdata[7:4] == 4'h0) else $error("upper bits set");
  a_rsv_offset: assert property ($past(i_raddr) == 2'h3 |-> o_rdata == 8'h0) else $error("reserved offset");
endmodule

//--- testbench/dse_regs_bench.sv
// self-checking bench for the pll status and event registers
`timescale 1ns/100ps
module dse_regs_bench;
  import dse_pkg::*;
  logic i_sys_clk = 0, i_reset_n = 0, i_clock_gated = 0, i_loop_soft_reset = 0;
  dse_loop_type i_loop = '0;
  dse_req_type  i_req = '0;
  logic [1:0]   i_raddr = 2'h0;
  logic [7:0]   o_rdata;
  int           bad_count = 0, comparisons = 0;
  dse_regs uut (.*);
  initial forever #2 i_sys_clk = ~i_sys_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(int n = 1);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    i_req = '{1'b1, a, d};
    tick();
    i_req.wr = 1'b0;
    tick();
  endtask
  task automatic chk(logic [1:0] a, logic [7:0] e);
    i_raddr = a;
    tick(2);
    comparisons++;
    if (o_rdata !== e)
    begin
      bad_count++;
      $display("[ERR] rdata %0h expected %h seen %h", a, e, o_rdata);
    end
  endtask
  task automatic lk(logic l);
    i_loop.locked = l;
    tick();
  endtask
  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(3);
    i_reset_n = 1'b1;
    i_loop = '{DSE_NORMAL, 1'b1, 1'b1};
    chk(2'h0, 8'h13);
    chk(2'h1, 8'h08);
    wr(2'h1, 8'h08);
    chk(2'h1, 8'h00);
    i_loop = '{DSE_HOLDOVER, 1'b1, 1'b0};
    chk(2'h1, 8'h0d);
    chk(2'h2, 8'h01);
    wr(2'h1, 8'h00);
    chk(2'h1, 8'h0d);
    wr(2'h1, 8'h0f);
    wr(2'h2, 8'h0e);
    lk(1'b1); lk(1'b0); lk(1'b1); lk(1'b0);
    chk(2'h2, 8'h0f);
    wr(2'h1, 8'h0f);
    chk(2'h1, 8'h02);
    i_clock_gated = 1'b1;
    wr(2'h2, 8'h00);
    chk(2'h2, 8'h0f);
    i_clock_gated = 1'b0;
    i_loop_soft_reset = 1'b1;
    wr(2'h2, 8'h00);
    chk(2'h2, 8'h0f);
    i_loop_soft_reset = 1'b0;
    wr(2'h2, 8'h00);
    chk(2'h2, 8'h00);
    wr(2'h1, 8'h0f);
    chk(2'h1, 8'h00);
    chk(2'h3, 8'h00);
    i_loop = '{DSE_HITLESS, 1'b0, 1'b0};
    chk(2'h0, 8'h50);
    chk(2'h1, 8'h08);
    complete_run();
  end
  // the sequence above needs well under 100 cycles
  initial
  begin
    #2000;
    bad_count++;
    complete_run();
  end
endmodule
bind dse_regs dse_regs_monitor #(.LOSS_THRESH(LOSS_THRESH)) mon (.*);
